// *** common/vesfr_pkg.sv ***
// constants, types and behaviour summary for the video error status and format report block
//
// Behaviour
// - hd mode: luma and chroma format codes reported in separate four-bit fields
// - sd or asi mode: code only in luma field, chroma field held at fh
// - both format fields return to fh on reset, lock loss, data-through
// - codes 0h..8h defined, 9h..eh reserved, fh means unknown format
// - all detection except lock is off in asi or data-through mode
// - status register at index 001h, one flag per error type, set on detection
// - status cleared at each field start or on host read, whichever first
// - non-lock flags cleared on standard change, reset, lock low, bypass low as slave
// - mask bits reset to zero; host writes one to disable detection of a type
// - active-low error pin is or of flags, high at rest, low on unmasked error
// - bit 10 flags payload identifier disagreeing with calculated video standard
// - bits 9 and 8 flag full-field and active-picture crc errors, sd only
// - bit 7 high whenever lock indication is low
// - bits 6 and 5 flag chroma and luma ancillary checksum errors; chroma hd only
// - bits 4 and 3 flag chroma and luma line crc errors, hd only
// - bit 2 flags received line number mismatch in hd operation
// - bits 1 and 0 flag trs errors; hd checks luma only; flywheel enable needed
// - mask register at index 01ah, each bit at its flag's position 10..0
package vesfr_pkg;

  // ************
  // widths
  // ************
  localparam int FLAG_W = 11;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int FMT_W  = 4;
  localparam int SYNC_W = 3;

  // ************
  // register indices and byte addresses (byte = index * 4)
  // ************
  localparam logic [9:0] IDX_FLAGS    = 10'h001;
  localparam logic [9:0] IDX_DISABLE  = 10'h01A;
  localparam logic [9:0] IDX_FORMAT   = 10'h020;
  localparam logic [9:0] IDX_INT_STAT = 10'h021;
  localparam logic [9:0] IDX_INT_EN   = 10'h022;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS    = {IDX_FLAGS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DISABLE  = {IDX_DISABLE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FORMAT   = {IDX_FORMAT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = {IDX_INT_STAT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_INT_EN   = {IDX_INT_EN, 2'h0};

  // ************
  // flag groups (positions shared by status, mask, interrupt regs)
  // ************
  localparam logic [FLAG_W-1:0] FLAGS_NONE = 11'h000;
  localparam logic [FLAG_W-1:0] FLAGS_ALL  = 11'h7FF;
  localparam logic [FLAG_W-1:0] M_LOCK     = 11'h080;
  localparam logic [FLAG_W-1:0] M_SD_ONLY  = 11'h300;
  localparam logic [FLAG_W-1:0] M_HD_ONLY  = 11'h05C;
  localparam logic [FLAG_W-1:0] M_TRS      = 11'h003;

  // ************
  // format field layout and codes
  // ************
  localparam int FMT_LUMA_LSB   = 0;
  localparam int FMT_CHROMA_LSB = 4;
  localparam logic [FMT_W-1:0] FMT_UNKNOWN  = 4'hF;
  localparam logic [FMT_W-1:0] FMT_LAST_DEF = 4'h8;

  // ************
  // bus encodings and synchroniser lanes
  // ************
  localparam logic       HRESP_OKAY = 1'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int SY_LOCK  = 0;
  localparam int SY_BYP   = 1;
  localparam int SY_SLAVE = 2;

  typedef enum logic {VESFR_BUS_IDLE, VESFR_BUS_DATA} vesfr_bus_t;

endpackage

// *** common/vesfr_sync_if.sv ***
// interface carrying pin levels to and from the synchroniser
`timescale 1ns/100ps
interface vesfr_sync_if;
  logic [vesfr_pkg::SYNC_W-1:0] raw;
  logic [vesfr_pkg::SYNC_W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface

// *** hw/vesfr_sync.sv ***
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module vesfr_sync (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // pin levels
  vesfr_sync_if.sync_side  sif
);
  import vesfr_pkg::*;

  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;

  // ************
  // one two-flop chain per lane; first stage feeds only second
  // ************
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_lane
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else if (ce) begin
          meta_reg[g] <= sif.raw[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign sif.synced = sync_reg;

endmodule

// *** hw/vesfr_top.sv ***
// error status, mask, interrupt and format report registers behind an ahb-lite slave
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
module vesfr_top (
  // clock, reset, enable
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [vesfr_pkg::DATA_W-1:0]  hwdata,
  input  wire logic                          hready,
  output logic      [vesfr_pkg::DATA_W-1:0]  hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // asynchronous pins
  input  wire logic                          locked,
  input  wire logic                          processing_bypass_n,
  input  wire logic                          slave_mode,
  // operating mode from core logic
  input  wire logic                          rate_select_sd_high,
  input  wire logic                          asi_mode,
  input  wire logic                          data_through,
  input  wire logic                          flywheel_enable,
  // detector events from core logic
  input  wire logic [vesfr_pkg::FLAG_W-1:0]  err_event,
  input  wire logic                          std_change,
  input  wire logic                          field_start,
  // format codes from core logic
  input  wire logic                          fmt_valid,
  input  wire logic [vesfr_pkg::FMT_W-1:0]   luma_format_code_in,
  input  wire logic [vesfr_pkg::FMT_W-1:0]   chroma_format_code_in,
  // status outputs
  output logic      [vesfr_pkg::FMT_W-1:0]   luma_format_code,
  output logic      [vesfr_pkg::FMT_W-1:0]   chroma_format_code,
  output logic                               data_error_n,
  output logic                               irq
);
  import vesfr_pkg::*;

  // ************
  // functions
  // ************

  // address match against one register byte address
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] target);
    reg_hit = (a == target);
  endfunction

  // reserved codes are reported as unknown
  function automatic logic [FMT_W-1:0] fmt_clean(input logic [FMT_W-1:0] c);
    fmt_clean = (c > FMT_LAST_DEF) ? FMT_UNKNOWN : c;
  endfunction

  // ************
  // declarations
  // ************
  vesfr_sync_if sif ();

  vesfr_bus_t          bus_state_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic                wr_reg;
  logic                hready_reg;
  logic [DATA_W-1:0]   hrdata_reg;
  logic [FLAG_W-1:0]   flags_reg;
  logic [FLAG_W-1:0]   flags_next;
  logic [FLAG_W-1:0]   disable_reg;
  logic [FLAG_W-1:0]   disable_next;
  logic [FLAG_W-1:0]   int_stat_reg;
  logic [FLAG_W-1:0]   int_stat_next;
  logic [FLAG_W-1:0]   int_en_reg;
  logic [FLAG_W-1:0]   int_en_next;
  logic [FMT_W-1:0]    luma_reg;
  logic [FMT_W-1:0]    luma_next;
  logic [FMT_W-1:0]    chroma_reg;
  logic [FMT_W-1:0]    chroma_next;
  logic                err_n_reg;
  logic                irq_reg;

  logic                locked_s;
  logic                bypass_n_s;
  logic                slave_s;
  logic                take;
  logic                act;
  logic                act_rd;
  logic                act_wr;
  logic                rd_flags;
  logic                wr_disable;
  logic                wr_int_stat;
  logic                wr_int_en;
  logic [DATA_W-1:0]   rd_word;
  logic                det_on;
  logic                hold_clr;
  logic                soft_clr;
  logic [FLAG_W-1:0]   mode_ok;
  logic [FLAG_W-1:0]   fw_ok;
  logic [FLAG_W-1:0]   lock_set;
  logic [FLAG_W-1:0]   set_vec;
  logic [FLAG_W-1:0]   clr_vec;
  logic [FLAG_W-1:0]   new_flags;
  logic [FLAG_W-1:0]   wdat;
  logic                fmt_force;
  logic                sd_or_asi;

  // ************
  // pin synchronisers
  // ************

  // pins cross two flops before any logic looks at them
  assign sif.raw[SY_LOCK]  = locked;
  assign sif.raw[SY_BYP]   = processing_bypass_n;
  assign sif.raw[SY_SLAVE] = slave_mode;

  vesfr_sync u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .sif   (sif.sync_side)
  );

  assign locked_s   = sif.synced[SY_LOCK];
  assign bypass_n_s = sif.synced[SY_BYP];
  assign slave_s    = sif.synced[SY_SLAVE];

  // ************
  // ahb-lite slave: one wait state, action when ce is high
  // ************

  // address phase taken, and data phase action
  assign take   = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign act    = (bus_state_reg == VESFR_BUS_DATA) & ce;
  assign act_rd = act & ~wr_reg;
  assign act_wr = act & wr_reg;

  // register selects
  assign rd_flags    = act_rd & reg_hit(addr_reg, ADDR_FLAGS);
  assign wr_disable  = act_wr & reg_hit(addr_reg, ADDR_DISABLE);
  assign wr_int_stat = act_wr & reg_hit(addr_reg, ADDR_INT_STAT);
  assign wr_int_en   = act_wr & reg_hit(addr_reg, ADDR_INT_EN);
  assign wdat        = hwdata[FLAG_W-1:0];

  // read mux; unmapped reads return zero, upper bits read zero
  always_comb begin
    rd_word = '0;
    if (reg_hit(addr_reg, ADDR_FLAGS)) begin
      rd_word[FLAG_W-1:0] = flags_reg;
    end else if (reg_hit(addr_reg, ADDR_DISABLE)) begin
      rd_word[FLAG_W-1:0] = disable_reg;
    end else if (reg_hit(addr_reg, ADDR_FORMAT)) begin
      rd_word[FMT_LUMA_LSB +: FMT_W]   = luma_reg;
      rd_word[FMT_CHROMA_LSB +: FMT_W] = chroma_reg;
    end else if (reg_hit(addr_reg, ADDR_INT_STAT)) begin
      rd_word[FLAG_W-1:0] = int_stat_reg;
    end else if (reg_hit(addr_reg, ADDR_INT_EN)) begin
      rd_word[FLAG_W-1:0] = int_en_reg;
    end
  end

  // bus handshake state; runs with ce low so the master is stalled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg <= VESFR_BUS_IDLE;
      hready_reg    <= 1'b1;
      addr_reg      <= '0;
      wr_reg        <= 1'b0;
    end else begin
      case (bus_state_reg)
        VESFR_BUS_IDLE: begin
          if (take) begin
            bus_state_reg <= VESFR_BUS_DATA;
            hready_reg    <= 1'b0;
            addr_reg      <= haddr[ADDR_W-1:0];
            wr_reg        <= hwrite;
          end
        end
        VESFR_BUS_DATA: begin
          if (ce) begin
            bus_state_reg <= VESFR_BUS_IDLE;
            hready_reg    <= 1'b1;
          end
        end
        default: begin
          bus_state_reg <= VESFR_BUS_IDLE;
          hready_reg    <= 1'b1;
        end
      endcase
    end
  end

  // read data captured at the end of the data phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_reg <= '0;
    end else if (act_rd) begin
      hrdata_reg <= rd_word;
    end
  end

  // ************
  // error detection qualifiers
  // ************

  // everything but lock is off in asi and data-through
  assign det_on = ~(asi_mode | data_through);

  // sd-only crc flags, hd-only line flags and chroma ancillary flag
  assign mode_ok = rate_select_sd_high ? ~M_HD_ONLY : ~M_SD_ONLY;

  // trs checks need the flywheel running
  assign fw_ok = flywheel_enable ? FLAGS_ALL : ~M_TRS;

  // lock flag set in every cycle that the lock level is low
  assign lock_set = locked_s ? FLAGS_NONE : M_LOCK;

  // lock low or bypass low as slave holds non-lock flags clear
  assign hold_clr = ~locked_s | (~bypass_n_s & slave_s);

  // detected, qualified and unmasked errors
  assign set_vec = ((err_event & ~M_LOCK & mode_ok & fw_ok & {FLAG_W{det_on & ~hold_clr}})
                    | lock_set) & ~disable_reg;

  // ************
  // error flags
  // ************

  // field start or host read clears all; other causes spare lock
  assign soft_clr = field_start | rd_flags;
  assign clr_vec  = ({FLAG_W{soft_clr}} | ({FLAG_W{std_change | hold_clr}} & ~M_LOCK));

  // a new error wins over any clear in the same cycle
  assign flags_next = (flags_reg & ~clr_vec) | set_vec;
  assign new_flags  = set_vec & ~flags_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= FLAGS_NONE;
    end else if (ce) begin
      flags_reg <= flags_next;
    end
  end

  // ************
  // mask register
  // ************
  assign disable_next = wr_disable ? wdat : disable_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      disable_reg <= FLAGS_NONE;
    end else if (ce) begin
      disable_reg <= disable_next;
    end
  end

  // ************
  // interrupt status (write one to clear) and enable
  // ************

  // a newly raised flag beats a clearing write
  assign int_stat_next = (int_stat_reg & ~({FLAG_W{wr_int_stat}} & wdat)) | new_flags;
  assign int_en_next   = wr_int_en ? wdat : int_en_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_reg <= FLAGS_NONE;
      int_en_reg   <= FLAGS_NONE;
    end else if (ce) begin
      int_stat_reg <= int_stat_next;
      int_en_reg   <= int_en_next;
    end
  end

  // ************
  // data format report
  // ************

  // lock loss or data-through forces unknown on both fields
  assign fmt_force = ~locked_s | data_through;
  assign sd_or_asi = rate_select_sd_high | asi_mode;

  always_comb begin
    luma_next   = luma_reg;
    chroma_next = chroma_reg;
    if (fmt_force) begin
      luma_next   = FMT_UNKNOWN;
      chroma_next = FMT_UNKNOWN;
    end else begin
      if (fmt_valid) begin
        luma_next   = fmt_clean(luma_format_code_in);
        chroma_next = fmt_clean(chroma_format_code_in);
      end
      if (sd_or_asi) begin
        chroma_next = FMT_UNKNOWN;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      luma_reg   <= FMT_UNKNOWN;
      chroma_reg <= FMT_UNKNOWN;
    end else if (ce) begin
      luma_reg   <= luma_next;
      chroma_reg <= chroma_next;
    end
  end

  // ************
  // error pin and interrupt line
  // ************

  // pin low while any unmasked flag is set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err_n_reg <= 1'b1;
      irq_reg   <= 1'b0;
    end else if (ce) begin
      err_n_reg <= ~|(flags_next & ~disable_next);
      irq_reg   <= |(int_stat_next & int_en_next);
    end
  end

  // ************
  // outputs
  // ************
  assign hrdata             = hrdata_reg;
  assign hreadyout          = hready_reg;
  assign hresp              = HRESP_OKAY;
  assign luma_format_code   = luma_reg;
  assign chroma_format_code = chroma_reg;
  assign data_error_n       = err_n_reg;
  assign irq                = irq_reg;

endmodule

// *** verification/vesfr_host_model.sv ***
// ahb-lite host model issuing single word transfers
`timescale 1ns/100ps
module vesfr_host (
  // clock
  input  wire logic                         clock,
  // ahb-lite master side
  output logic                              hsel,
  output logic      [31:0]                  haddr,
  output logic      [1:0]                   htrans,
  output logic                              hwrite,
  output logic      [2:0]                   hsize,
  output logic      [vesfr_pkg::DATA_W-1:0] hwdata,
  input  wire logic                         hready,
  input  wire logic [vesfr_pkg::DATA_W-1:0] hrdata
);
  import vesfr_pkg::*;
  // bus at rest until the first transfer
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
  end
  // one transfer; entered right after a rising edge, waits as long as the slave stalls
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'h1;
    haddr <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'h1);
    rd = hrdata;
    hwdata <= ~wd;  // released data never keeps its last value
  endtask
endmodule

// *** verification/vesfr_monitor.sv ***
// concurrent checks on the ports of the error status and format report block
`timescale 1ns/100ps
module vesfr_monitor (
  // clock and reset
  input wire logic                         clock,
  input wire logic                         rst_n,
  input wire logic                         ce,
  // bus
  input wire logic                         hsel,
  input wire logic [1:0]                   htrans,
  input wire logic                         hready,
  input wire logic                         hreadyout,
  input wire logic                         hresp,
  // modes and events
  input wire logic                         locked,
  input wire logic                         rate_select_sd_high,
  input wire logic                         asi_mode,
  input wire logic                         data_through,
  input wire logic [vesfr_pkg::FLAG_W-1:0] err_event,
  input wire logic                         field_start,
  input wire logic                         fmt_valid,
  input wire logic [vesfr_pkg::FMT_W-1:0]  luma_format_code_in,
  input wire logic [vesfr_pkg::FMT_W-1:0]  chroma_format_code_in,
  // outputs
  input wire logic [vesfr_pkg::FMT_W-1:0]  luma_format_code,
  input wire logic [vesfr_pkg::FMT_W-1:0]  chroma_format_code,
  input wire logic                         data_error_n
);
  import vesfr_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ************
  // sequences and properties
  // ************
  sequence s_locked; locked [*4]; endsequence
  sequence s_take; ce && hsel && hready && htrans == HTRANS_NONSEQ && hreadyout; endsequence
  sequence s_load; ce && fmt_valid; endsequence
  sequence s_unk; luma_format_code == FMT_UNKNOWN && chroma_format_code == FMT_UNKNOWN; endsequence
  property p_wait; s_take ##1 ce |-> !hreadyout ##1 hreadyout; endproperty
  property p_okay; hresp == HRESP_OKAY; endproperty
  property p_fmt_hd;
    s_locked ##0 s_load ##0 (!rate_select_sd_high && !asi_mode && !data_through &&
      luma_format_code_in <= FMT_LAST_DEF && chroma_format_code_in <= FMT_LAST_DEF)
    |=> luma_format_code == $past(luma_format_code_in) &&
        chroma_format_code == $past(chroma_format_code_in);
  endproperty
  property p_fmt_sd; s_load ##0 (rate_select_sd_high || asi_mode) |=> chroma_format_code == FMT_UNKNOWN; endproperty
  property p_fmt_rsv; s_load ##0 (luma_format_code_in > FMT_LAST_DEF) |=> luma_format_code == FMT_UNKNOWN; endproperty
  property p_fmt_dt; ce && data_through |=> s_unk; endproperty
  property p_fmt_lock; (!locked && ce && !fmt_valid) [*4] |=> s_unk; endproperty
  property p_pin_rest; $rose(rst_n) |-> data_error_n; endproperty
  property p_pin_cause;
    $fell(data_error_n) |-> $past(err_event) != FLAGS_NONE || $rose(hreadyout) ||
      !($past(locked, 2) && $past(locked, 3) && $past(locked, 4));
  endproperty
  property p_quiet;
    s_locked ##0 (ce && (asi_mode || data_through) && hreadyout && htrans != HTRANS_NONSEQ)
    |=> !$fell(data_error_n);
  endproperty
  property p_field_clr; s_locked ##0 (ce && field_start && err_event == FLAGS_NONE) |=> data_error_n; endproperty
  a_wait: assert property (p_wait) else $error("bus wait not one cycle");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_fmt_hd: assert property (p_fmt_hd) else $error("hd format codes not reported");
  a_fmt_sd: assert property (p_fmt_sd) else $error("chroma code not unknown in sd");
  a_fmt_rsv: assert property (p_fmt_rsv) else $error("reserved code not unknown");
  a_fmt_dt: assert property (p_fmt_dt) else $error("format kept in data-through");
  a_fmt_lock: assert property (p_fmt_lock) else $error("format kept without lock");
  a_pin_rest: assert property (p_pin_rest) else $error("error pin low after reset");
  a_pin_cause: assert property (p_pin_cause) else $error("error pin fell without cause");
  a_quiet: assert property (p_quiet) else $error("error raised in asi or data-through");
  a_field_clr: assert property (p_field_clr) else $error("field start left errors");
endmodule
bind vesfr_top vesfr_monitor u_mon (
  .clock, .rst_n, .ce, .hsel, .htrans, .hready, .hreadyout, .hresp, .locked,
  .rate_select_sd_high, .asi_mode, .data_through, .err_event, .field_start, .fmt_valid,
  .luma_format_code_in, .chroma_format_code_in, .luma_format_code, .chroma_format_code,
  .data_error_n
);

// *** verification/test_video_error_status_and_format_report.sv ***
// self-checking bench for the error status and format report block
`timescale 1ns/100ps
module test_video_error_status_and_format_report;
  import vesfr_pkg::*;
  // ************
  // signals, instances, checks
  // ************
  logic              clock, rst_n, ce, hsel, hwrite, hreadyout, hresp, irq, data_error_n;
  logic              locked, processing_bypass_n, slave_mode, rate_select_sd_high;
  logic              asi_mode, data_through, flywheel_enable, std_change, field_start;
  logic              fmt_valid, sd_v, fw_v;
  logic [31:0]       haddr, hwdata, hrdata, rdata;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [FLAG_W-1:0] err_event, ev, msk, exp;
  logic [FMT_W-1:0]  luma_format_code_in, chroma_format_code_in, lc, cc;
  logic [FMT_W-1:0]  luma_format_code, chroma_format_code;
  logic [7:0]        exp_fmt;
  wire logic         hready;
  int                n_mismatch = 0, comparisons = 0, cycles = 0, seed, r;
  assign hready = hreadyout;
  vesfr_top dut (.clock, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .locked, .processing_bypass_n, .slave_mode,
    .rate_select_sd_high, .asi_mode, .data_through, .flywheel_enable, .err_event,
    .std_change, .field_start, .fmt_valid, .luma_format_code_in, .chroma_format_code_in,
    .luma_format_code, .chroma_format_code, .data_error_n, .irq);
  vesfr_host host (.clock, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d, rdata);
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] expv);
    host.xfer(1'h0, a, 32'h0, rdata);
    check(what, rdata, expv);
  endtask
  // one-cycle detector pulses, then one edge for the flags to land
  task automatic pulse(input logic [FLAG_W-1:0] e, input logic fs, input logic sc);
    err_event <= e;
    field_start <= fs;
    std_change <= sc;
    @(posedge clock);
    err_event <= FLAGS_NONE;
    field_start <= 1'h0;
    std_change <= 1'h0;
    @(posedge clock);
  endtask
  // flags that a detector pulse should leave behind in the given mode
  function automatic logic [FLAG_W-1:0] qual(input logic [FLAG_W-1:0] e, input logic sd,
                                             input logic fw, input logic off);
    logic [FLAG_W-1:0] q;
    q = e & ~M_LOCK & (sd ? ~M_HD_ONLY : ~M_SD_ONLY);
    if (!fw) q = q & ~M_TRS;
    return off ? FLAGS_NONE : q;
  endfunction
  // clock and hang ceiling
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // main sequence
  initial begin
    seed = 74136;
    {rst_n, locked, slave_mode, rate_select_sd_high, asi_mode, data_through} = 6'h0;
    {ce, processing_bypass_n, flywheel_enable} = 3'h7;
    {std_change, field_start, fmt_valid} = 3'h0;
    err_event = FLAGS_NONE;
    luma_format_code_in = 4'h0;
    chroma_format_code_in = 4'h0;
    repeat (3) @(posedge clock);
    rst_n <= 1'h1;
    repeat (4) @(posedge clock);
    check("luma after reset", luma_format_code, FMT_UNKNOWN);
    rd("flags unlocked", ADDR_FLAGS, 32'h80);
    locked <= 1'h1;
    repeat (4) @(posedge clock);
    rd("flags relocked", ADDR_FLAGS, 32'h80);
    rd("flags cleared", ADDR_FLAGS, 32'h0);
    rd("mask reset", ADDR_DISABLE, 32'h0);
    wr(12'hFFC, 32'hFFFFFFFF);
    rd("unmapped", 12'hFFC, 32'h0);
    check("pin idle", data_error_n, 1'h1);
    for (int i = 0; i < 48; i++) begin
      msk = (i % 4 == 3) ? 11'($random(seed)) : FLAGS_NONE;
      wr(ADDR_DISABLE, {21'h0, msk});
      rd("mask", ADDR_DISABLE, {21'h0, msk});
      sd_v = 1'($random(seed));
      fw_v = 1'($random(seed));
      r = $random(seed) % 8;
      rate_select_sd_high <= sd_v;
      flywheel_enable <= fw_v;
      asi_mode <= (r == 1);
      data_through <= (r == 2);
      ev = (i == 0) ? FLAGS_ALL : 11'($random(seed));
      pulse(ev, 1'h0, 1'h0);
      exp = qual(ev, sd_v, fw_v, r == 1 || r == 2) & ~msk;
      check("pin", data_error_n, exp == FLAGS_NONE);
      rd("flags", ADDR_FLAGS, {21'h0, exp});
      @(posedge clock);
      check("pin after read", data_error_n, 1'h1);
    end
    {rate_select_sd_high, asi_mode, data_through} <= 3'h0;
    flywheel_enable <= 1'h1;
    wr(ADDR_DISABLE, 32'h0);
    pulse(11'h400, 1'h0, 1'h0);
    pulse(FLAGS_NONE, 1'h1, 1'h0);
    rd("field clear", ADDR_FLAGS, 32'h0);
    pulse(11'h400, 1'h0, 1'h0);
    pulse(11'h020, 1'h1, 1'h0);
    rd("set beats field clear", ADDR_FLAGS, 32'h20);
    fork
      rd("read before set", ADDR_FLAGS, 32'h0);
      begin
        @(posedge clock);
        pulse(11'h400, 1'h0, 1'h0);
      end
    join
    rd("set beats read clear", ADDR_FLAGS, 32'h400);
    pulse(11'h020, 1'h0, 1'h0);
    locked <= 1'h0;
    repeat (4) @(posedge clock);
    locked <= 1'h1;
    repeat (4) @(posedge clock);
    pulse(11'h400, 1'h0, 1'h0);
    pulse(FLAGS_NONE, 1'h0, 1'h1);
    rd("lock and standard clear", ADDR_FLAGS, 32'h80);
    for (int s = 1; s >= 0; s--) begin
      pulse(11'h400, 1'h0, 1'h0);
      slave_mode <= s[0];
      processing_bypass_n <= 1'h0;
      repeat (4) @(posedge clock);
      processing_bypass_n <= 1'h1;
      repeat (4) @(posedge clock);
      rd("bypass clear", ADDR_FLAGS, s[0] ? 32'h0 : 32'h400);
    end
    for (int m = 0; m < 12; m++) begin
      lc = 4'(m);
      cc = 4'(11 - m);
      rate_select_sd_high <= (m % 4 == 1);
      asi_mode <= (m % 4 == 2);
      data_through <= (m % 4 == 3);
      fmt_valid <= 1'h1;
      luma_format_code_in <= lc;
      chroma_format_code_in <= cc;
      @(posedge clock);
      fmt_valid <= 1'h0;
      @(posedge clock);
      exp_fmt[3:0] = (m % 4 == 3 || lc > FMT_LAST_DEF) ? FMT_UNKNOWN : lc;
      exp_fmt[7:4] = (m % 4 != 0 || cc > FMT_LAST_DEF) ? FMT_UNKNOWN : cc;
      check("chroma out", chroma_format_code, exp_fmt[7:4]);
      rd("format", ADDR_FORMAT, {24'h0, exp_fmt});
    end
    {rate_select_sd_high, asi_mode, data_through} <= 3'h0;
    locked <= 1'h0;
    repeat (4) @(posedge clock);
    rd("format unlocked", ADDR_FORMAT, 32'hFF);
    locked <= 1'h1;
    repeat (4) @(posedge clock);
    wr(ADDR_INT_STAT, 32'h7FF);
    rd("flags lock", ADDR_FLAGS, 32'h80);
    pulse(11'h020, 1'h0, 1'h0);
    check("irq disabled", irq, 1'h0);
    wr(ADDR_INT_EN, 32'h20);
    @(posedge clock);
    check("irq raised", irq, 1'h1);
    rd("int status", ADDR_INT_STAT, 32'h20);
    wr(ADDR_INT_STAT, 32'h20);
    @(posedge clock);
    check("irq cleared", irq, 1'h0);
    ce <= 1'h0;
    pulse(11'h400, 1'h0, 1'h0);
    ce <= 1'h1;
    rd("frozen", ADDR_FLAGS, 32'h20);
    end_sim();
  end
endmodule
